// ==== rtl/bcb_pkg.sv ====
`default_nettype none

package bcb_pkg;

  // ---------------------------------------------------------------
  // Operations and branch conditions
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_IDLE,
    BIT_OR_INTO_CARRY,
    INVERTED_BIT_OR_TO_CARRY,
    BIT_XOR_INTO_CARRY,
    INVERTED_BIT_XOR_TO_CARRY,
    LOAD_BIT_TO_CARRY,
    LOAD_INVERTED_BIT_TO_CARRY,
    STORE_CARRY_TO_BIT,
    STORE_INVERTED_CARRY_TO_BIT,
    OP_COND_BRANCH,
    ABSOLUTE_JUMP,
    RELATIVE_SUBROUTINE_CALL,
    ABSOLUTE_SUBROUTINE_CALL,
    OP_SUBROUTINE_RETURN
  } bcb_op_t;

  typedef enum logic [3:0] {
    UNCONDITIONAL_RELATIVE_JUMP,
    NEVER_TAKEN_BRANCH,
    UNSIGNED_HIGHER_TEST,
    UNSIGNED_LOWER_OR_SAME_TEST,
    COND_CARRY_CLEAR,
    COND_CARRY_SET,
    COND_NOT_EQUAL,
    COND_EQUAL,
    COND_OVERFLOW_CLEAR,
    COND_OVERFLOW_SET,
    COND_PLUS,
    COND_MINUS,
    SIGNED_GREATER_EQUAL_TEST,
    SIGNED_LESS_TEST,
    SIGNED_GREATER_TEST,
    SIGNED_LESS_EQUAL_TEST
  } bcb_cond_t;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int         BIT_IDX_W   = 3;
  localparam int         BYTE_W      = 8;
  localparam logic       FLAG_RST    = 1'b0;
  localparam logic [7:0] BYTE_RST    = 8'h00;

endpackage : bcb_pkg

`default_nettype wire

// ==== rtl/bcb_unit.sv ====
// Contract
// - OR carry with selected operand bit
// - OR carry with inverted operand bit
// - XOR carry with selected operand bit
// - XOR carry with inverted operand bit
// - Load selected operand bit into carry
// - Load inverted operand bit into carry
// - Store carry into selected operand bit
// - Store inverted carry into selected bit
// - Inverted forms take bit index from immediate
// - Branch taken only when condition holds
// - Compound conditions from C, Z, N, V
// - Jump loads target unconditionally
// - Calls transfer to the target address unless the stack is full
// - Plain forms: immediate or register low bits
// - Stores write back the whole modified byte
`timescale 1ns/1ps
`default_nettype none

module bcb_unit #(
  parameter int ADDR_W      = 24,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                opValid,
  input  wire bcb_pkg::bcb_op_t    opCode,
  input  wire bcb_pkg::bcb_cond_t  condCode,
  input  wire logic [2:0]          bitImm,
  input  wire logic [7:0]          bitReg,
  input  wire logic                bitFromReg,
  input  wire logic [7:0]          operandByte,
  input  wire logic [ADDR_W-1:0]   targetAddr,
  input  wire logic [ADDR_W-1:0]   returnAddr,
  input  wire logic                flagLoad,
  input  wire logic [3:0]          flagIn,
  output logic                     carryFlag,
  output logic                     zeroFlag,
  output logic                     overflowFlag,
  output logic                     negativeFlag,
  output logic [7:0]               resultByte,
  output logic                     resultByteWrite,
  output logic [ADDR_W-1:0]        pcValue,
  output logic                     pcLoad,
  output logic                     opDone,
  output logic                     stackFault
);

  localparam int SP_W = $clog2(STACK_DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                                  c;
    logic                                  z;
    logic                                  v;
    logic                                  n;
    logic [7:0]                            byteOut;
    logic                                  byteWr;
    logic [ADDR_W-1:0]                     pc;
    logic                                  pcLd;
    logic                                  done;
    logic                                  fault;
    logic [SP_W-1:0]                       sp;
    logic [STACK_DEPTH-1:0][ADDR_W-1:0]    stack;
  } bcb_state_t;

  bcb_state_t stateQ;
  bcb_state_t stateD;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic isInverted(input bcb_pkg::bcb_op_t op);
    isInverted = op inside {bcb_pkg::INVERTED_BIT_OR_TO_CARRY,
                            bcb_pkg::INVERTED_BIT_XOR_TO_CARRY,
                            bcb_pkg::LOAD_INVERTED_BIT_TO_CARRY,
                            bcb_pkg::STORE_INVERTED_CARRY_TO_BIT};
  endfunction : isInverted

  function automatic logic isBitOp(input bcb_pkg::bcb_op_t op);
    isBitOp = op inside {[bcb_pkg::BIT_OR_INTO_CARRY :
                          bcb_pkg::STORE_INVERTED_CARRY_TO_BIT]};
  endfunction : isBitOp

  function automatic logic condHolds(input bcb_pkg::bcb_cond_t cc,
                                     input logic c, input logic z,
                                     input logic v, input logic n);
    case (cc)
      bcb_pkg::UNCONDITIONAL_RELATIVE_JUMP: condHolds = 1'b1;
      bcb_pkg::NEVER_TAKEN_BRANCH:          condHolds = 1'b0;
      bcb_pkg::UNSIGNED_HIGHER_TEST:        condHolds = !(c | z);
      bcb_pkg::UNSIGNED_LOWER_OR_SAME_TEST: condHolds = c | z;
      bcb_pkg::COND_CARRY_CLEAR:            condHolds = !c;
      bcb_pkg::COND_CARRY_SET:              condHolds = c;
      bcb_pkg::COND_NOT_EQUAL:              condHolds = !z;
      bcb_pkg::COND_EQUAL:                  condHolds = z;
      bcb_pkg::COND_OVERFLOW_CLEAR:         condHolds = !v;
      bcb_pkg::COND_OVERFLOW_SET:           condHolds = v;
      bcb_pkg::COND_PLUS:                   condHolds = !n;
      bcb_pkg::COND_MINUS:                  condHolds = n;
      bcb_pkg::SIGNED_GREATER_EQUAL_TEST:   condHolds = !(n ^ v);
      bcb_pkg::SIGNED_LESS_TEST:            condHolds = n ^ v;
      bcb_pkg::SIGNED_GREATER_TEST:         condHolds = !(z | (n ^ v));
      bcb_pkg::SIGNED_LESS_EQUAL_TEST:      condHolds = z | (n ^ v);
      default:                              condHolds = 1'b0;
    endcase
  endfunction : condHolds

  logic [bcb_pkg::BIT_IDX_W-1:0] selIdx;
  logic [7:0]                    selMask;
  logic                          selBit;
  logic                          condOk;
  logic                          stackFull;
  logic                          stackEmpty;

  always_comb begin
    if (bitFromReg && !isInverted(opCode)) begin
      selIdx = bitReg[bcb_pkg::BIT_IDX_W-1:0];
    end else begin
      selIdx = bitImm;
    end
    selMask    = 8'h01 << selIdx;
    selBit     = operandByte[selIdx];
    condOk     = condHolds(condCode, stateQ.c, stateQ.z, stateQ.v, stateQ.n);
    stackFull  = stateQ.sp == SP_FULL;
    stackEmpty = stateQ.sp == '0;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    stateD        = stateQ;
    stateD.byteWr = 1'b0;
    stateD.pcLd   = 1'b0;
    stateD.done   = 1'b0;
    stateD.fault  = 1'b0;
    if (flagLoad && !opValid) begin
      {stateD.c, stateD.z, stateD.v, stateD.n} = flagIn;
    end
    if (opValid) begin
      stateD.done = 1'b1;
      case (opCode)
        bcb_pkg::BIT_OR_INTO_CARRY: begin
          stateD.c = stateQ.c | selBit;
        end
        bcb_pkg::INVERTED_BIT_OR_TO_CARRY: begin
          stateD.c = stateQ.c | !selBit;
        end
        bcb_pkg::BIT_XOR_INTO_CARRY: begin
          stateD.c = stateQ.c ^ selBit;
        end
        bcb_pkg::INVERTED_BIT_XOR_TO_CARRY: begin
          stateD.c = stateQ.c ^ !selBit;
        end
        bcb_pkg::LOAD_BIT_TO_CARRY: begin
          stateD.c = selBit;
        end
        bcb_pkg::LOAD_INVERTED_BIT_TO_CARRY: begin
          stateD.c = !selBit;
        end
        bcb_pkg::STORE_CARRY_TO_BIT: begin
          stateD.byteOut = stateQ.c ? (operandByte | selMask)
                                    : (operandByte & ~selMask);
          stateD.byteWr  = 1'b1;
        end
        bcb_pkg::STORE_INVERTED_CARRY_TO_BIT: begin
          stateD.byteOut = stateQ.c ? (operandByte & ~selMask)
                                    : (operandByte | selMask);
          stateD.byteWr  = 1'b1;
        end
        bcb_pkg::OP_COND_BRANCH: begin
          if (condOk) begin
            stateD.pc   = targetAddr;
            stateD.pcLd = 1'b1;
          end
        end
        bcb_pkg::ABSOLUTE_JUMP: begin
          stateD.pc   = targetAddr;
          stateD.pcLd = 1'b1;
        end
        bcb_pkg::RELATIVE_SUBROUTINE_CALL,
        bcb_pkg::ABSOLUTE_SUBROUTINE_CALL: begin
          if (stackFull) begin
            stateD.fault = 1'b1;
          end else begin
            stateD.stack[stateQ.sp[SP_W-1:0]] = returnAddr;
            stateD.sp   = stateQ.sp + SP_W'(1);
            stateD.pc   = targetAddr;
            stateD.pcLd = 1'b1;
          end
        end
        bcb_pkg::OP_SUBROUTINE_RETURN: begin
          if (stackEmpty) begin
            stateD.fault = 1'b1;
          end else begin
            stateD.sp   = stateQ.sp - SP_W'(1);
            stateD.pc   = stateQ.stack[stateQ.sp - SP_W'(1)];
            stateD.pcLd = 1'b1;
          end
        end
        default: begin
          stateD.done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateQ         <= '0;
      stateQ.c       <= bcb_pkg::FLAG_RST;
      stateQ.z       <= bcb_pkg::FLAG_RST;
      stateQ.v       <= bcb_pkg::FLAG_RST;
      stateQ.n       <= bcb_pkg::FLAG_RST;
      stateQ.byteOut <= bcb_pkg::BYTE_RST;
    end else begin
      stateQ <= stateD;
    end
  end

  assign carryFlag       = stateQ.c;
  assign zeroFlag        = stateQ.z;
  assign overflowFlag    = stateQ.v;
  assign negativeFlag    = stateQ.n;
  assign resultByte      = stateQ.byteOut;
  assign resultByteWrite = stateQ.byteWr;
  assign pcValue         = stateQ.pc;
  assign pcLoad          = stateQ.pcLd;
  assign opDone          = stateQ.done;
  assign stackFault      = stateQ.fault;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence callIssued;
    opValid && !stackFull &&
    opCode inside {bcb_pkg::RELATIVE_SUBROUTINE_CALL,
                   bcb_pkg::ABSOLUTE_SUBROUTINE_CALL};
  endsequence

  sequence returnIssued;
    opValid && opCode == bcb_pkg::OP_SUBROUTINE_RETURN;
  endsequence

  or_carry_a: assert property (
    opValid && opCode == bcb_pkg::BIT_OR_INTO_CARRY |=>
      carryFlag == ($past(carryFlag) | $past(selBit)))
    else $error("carry OR result wrong");

  ior_carry_a: assert property (
    opValid && opCode == bcb_pkg::INVERTED_BIT_OR_TO_CARRY |=>
      carryFlag == ($past(carryFlag) | !$past(selBit)))
    else $error("inverted carry OR result wrong");

  xor_carry_a: assert property (
    opValid && opCode == bcb_pkg::BIT_XOR_INTO_CARRY |=>
      carryFlag == ($past(carryFlag) ^ $past(selBit)))
    else $error("carry XOR result wrong");

  ixor_carry_a: assert property (
    opValid && opCode == bcb_pkg::INVERTED_BIT_XOR_TO_CARRY |=>
      carryFlag != ($past(carryFlag) ^ $past(selBit)))
    else $error("inverted carry XOR result wrong");

  load_carry_a: assert property (
    opValid && opCode == bcb_pkg::LOAD_BIT_TO_CARRY |=>
      carryFlag == $past(operandByte[selIdx]))
    else $error("bit load wrong");

  iload_carry_a: assert property (
    opValid && opCode == bcb_pkg::LOAD_INVERTED_BIT_TO_CARRY |=>
      carryFlag != $past(selBit))
    else $error("inverted bit load wrong");

  store_bit_a: assert property (
    opValid && opCode == bcb_pkg::STORE_CARRY_TO_BIT |=>
      resultByteWrite && carryFlag == resultByte[$past(selIdx)])
    else $error("bit store wrong");

  istore_bit_a: assert property (
    opValid && opCode == bcb_pkg::STORE_INVERTED_CARRY_TO_BIT |=>
      resultByteWrite && carryFlag != resultByte[$past(selIdx)])
    else $error("inverted bit store wrong");

  inv_index_a: assert property (
    opValid && isInverted(opCode) |-> selIdx == bitImm)
    else $error("inverted op took register index");

  byte_keep_a: assert property (
    opValid && opCode inside {bcb_pkg::STORE_CARRY_TO_BIT,
                              bcb_pkg::STORE_INVERTED_CARRY_TO_BIT} |=>
      ((resultByte ^ $past(operandByte)) & ~$past(selMask)) == 8'h00)
    else $error("store disturbed other bits");

  branch_take_a: assert property (
    opValid && opCode == bcb_pkg::OP_COND_BRANCH |=>
      pcLoad == $past(condOk) && (!pcLoad || pcValue == $past(targetAddr)))
    else $error("branch decision wrong");

  greater_cond_a: assert property (
    opValid && opCode == bcb_pkg::OP_COND_BRANCH &&
    condCode == bcb_pkg::SIGNED_GREATER_TEST |=>
      pcLoad == !($past(zeroFlag) | ($past(negativeFlag) ^
                                     $past(overflowFlag))))
    else $error("greater-than condition wrong");

  jump_load_a: assert property (
    opValid && opCode == bcb_pkg::ABSOLUTE_JUMP |=>
      pcLoad && pcValue == $past(targetAddr))
    else $error("jump did not load target");

  call_target_a: assert property (
    callIssued |=> pcLoad && pcValue == $past(targetAddr))
    else $error("call did not reach target");

  call_return_a: assert property (
    callIssued ##1 returnIssued |=>
      pcLoad && pcValue == $past(returnAddr, 2))
    else $error("return address not restored");

  flags_keep_a: assert property (
    opValid && isBitOp(opCode) |=>
      {zeroFlag, overflowFlag, negativeFlag} ==
      $past({zeroFlag, overflowFlag, negativeFlag}))
    else $error("bit op touched Z V N");

endmodule : bcb_unit

`default_nettype wire

// ==== verif/bit_carry_logic_and_branch_unit_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module bit_carry_logic_and_branch_unit_bench;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct packed {
    bcb_pkg::bcb_op_t op;
    logic [3:0]       fl;
    logic [2:0]       imm;
    logic [7:0]       rg;
    logic             fr;
    logic [7:0]       b;
    logic             expC;
    logic             expWr;
    logic [7:0]       expB;
  } bcb_row_t;

  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               opValid = 1'b0;
  bcb_pkg::bcb_op_t   opCode = bcb_pkg::OP_IDLE;
  bcb_pkg::bcb_cond_t condCode = bcb_pkg::UNCONDITIONAL_RELATIVE_JUMP;
  logic [2:0]         bitImm = 3'h0;
  logic [7:0]         bitReg = 8'h00;
  logic               bitFromReg = 1'b0;
  logic [7:0]         operandByte = 8'h00;
  logic [23:0]        targetAddr = 24'h000000;
  logic [23:0]        returnAddr = 24'h000000;
  logic               flagLoad = 1'b0;
  logic [3:0]         flagIn = 4'h0;
  logic               carryFlag, zeroFlag, overflowFlag, negativeFlag;
  logic [7:0]         resultByte;
  logic               resultByteWrite, pcLoad, opDone, stackFault;
  logic [23:0]        pcValue;
  int                 errors = 0;
  int                 samplesChecked = 0;
  int                 cycles = 0;

  bcb_row_t rows [11] = '{
    '{bcb_pkg::BIT_OR_INTO_CARRY,
      4'h5, 3'h2, 8'h00, 1'b0, 8'h04, 1'b1, 1'b0, 8'h00},
    '{bcb_pkg::BIT_OR_INTO_CARRY,
      4'h5, 3'h3, 8'h00, 1'b0, 8'h04, 1'b0, 1'b0, 8'h00},
    '{bcb_pkg::BIT_OR_INTO_CARRY,
      4'h5, 3'h0, 8'hfa, 1'b1, 8'h04, 1'b1, 1'b0, 8'h00},
    '{bcb_pkg::INVERTED_BIT_OR_TO_CARRY,
      4'h5, 3'h2, 8'h00, 1'b1, 8'hfb, 1'b1, 1'b0, 8'h00},
    '{bcb_pkg::BIT_XOR_INTO_CARRY,
      4'hd, 3'h7, 8'h00, 1'b0, 8'h80, 1'b0, 1'b0, 8'h00},
    '{bcb_pkg::INVERTED_BIT_XOR_TO_CARRY,
      4'hd, 3'h7, 8'h06, 1'b1, 8'h80, 1'b1, 1'b0, 8'h00},
    '{bcb_pkg::LOAD_BIT_TO_CARRY,
      4'hd, 3'h5, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00},
    '{bcb_pkg::LOAD_INVERTED_BIT_TO_CARRY,
      4'h5, 3'h5, 8'h01, 1'b1, 8'h02, 1'b1, 1'b0, 8'h00},
    '{bcb_pkg::STORE_CARRY_TO_BIT,
      4'hd, 3'h3, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1, 8'h08},
    '{bcb_pkg::STORE_CARRY_TO_BIT,
      4'h5, 3'h0, 8'hff, 1'b1, 8'hff, 1'b0, 1'b1, 8'h7f},
    '{bcb_pkg::STORE_INVERTED_CARRY_TO_BIT,
      4'hd, 3'h4, 8'h00, 1'b1, 8'hff, 1'b1, 1'b1, 8'hef}
  };

  bcb_unit #(
    .ADDR_W      (24),
    .STACK_DEPTH (2)
  ) i_dut (
    .clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode),
    .condCode(condCode), .bitImm(bitImm), .bitReg(bitReg),
    .bitFromReg(bitFromReg), .operandByte(operandByte),
    .targetAddr(targetAddr), .returnAddr(returnAddr), .flagLoad(flagLoad),
    .flagIn(flagIn), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .overflowFlag(overflowFlag), .negativeFlag(negativeFlag),
    .resultByte(resultByte), .resultByteWrite(resultByteWrite),
    .pcValue(pcValue), .pcLoad(pcLoad), .opDone(opDone),
    .stackFault(stackFault)
  );

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp,
                     input string msg);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp

  task automatic setFlags(input logic [3:0] f);
    @(posedge clk_sys);
    flagLoad <= 1'b1;
    flagIn   <= f;
    @(posedge clk_sys);
    flagLoad <= 1'b0;
  endtask : setFlags

  // One op, then outputs are settled 1 ns after the taking edge
  task automatic doOp(input bcb_pkg::bcb_op_t op, input logic [3:0] cc,
                      input logic [2:0] imm, input logic [7:0] rg,
                      input logic fr, input logic [7:0] b,
                      input logic [23:0] tgt, input logic [23:0] ra);
    @(posedge clk_sys);
    opValid     <= 1'b1;
    opCode      <= op;
    condCode    <= bcb_pkg::bcb_cond_t'(cc);
    bitImm      <= imm;
    bitReg      <= rg;
    bitFromReg  <= fr;
    operandByte <= b;
    targetAddr  <= tgt;
    returnAddr  <= ra;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    cmp(24'(opDone), 24'h1, "done pulse");
  endtask : doOp

  function automatic logic expTaken(input logic [3:0] cc,
                                    input logic [3:0] f);
    logic c, z, v, n;
    {c, z, v, n} = f;
    case (cc)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !(c | z);
      4'h3: return c | z;
      4'h4: return !c;
      4'h5: return c;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'ha: return !n;
      4'hb: return n;
      4'hc: return !(n ^ v);
      4'hd: return n ^ v;
      4'he: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction : expTaken

  task automatic call(input bcb_pkg::bcb_op_t op, input logic [23:0] t,
                      input logic [23:0] r, input logic flt);
    doOp(op, 4'h0, 3'h0, 8'h00, 1'b0, 8'h00, t, r);
    cmp(24'(stackFault), 24'(flt), "stack fault");
    cmp(24'(pcLoad), 24'(!flt), "pc load");
    if (!flt)
      cmp(pcValue, t, "pc value");
  endtask : call

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [23:0] tgt;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    cmp(pcValue, 24'h0, "reset pc");
    cmp(24'({carryFlag, opDone, pcLoad}), 24'h0, "reset state");
    foreach (rows[i]) begin
      setFlags(rows[i].fl);
      doOp(rows[i].op, 4'h0, rows[i].imm, rows[i].rg, rows[i].fr,
           rows[i].b, 24'h0, 24'h0);
      cmp(24'(carryFlag), 24'(rows[i].expC),
          "carry");
      cmp(24'({zeroFlag, overflowFlag, negativeFlag}), 24'h5,
          "zvn");
      cmp(24'(resultByteWrite), 24'(rows[i].expWr), "write");
      if (rows[i].expWr)
        cmp(24'(resultByte), 24'(rows[i].expB),
            "byte");
      cmp(24'(pcLoad), 24'h0, "no pc load");
    end
    for (int k = 0; k < 16; k++) begin
      for (int f = 0; f < 16; f++) begin
        setFlags(f[3:0]);
        tgt = {k[3:0], f[3:0], 16'h1234};
        doOp(bcb_pkg::OP_COND_BRANCH, k[3:0], 3'h0, 8'h00, 1'b0, 8'h00,
             tgt, 24'h0);
        cmp(24'(pcLoad), 24'(expTaken(k[3:0], f[3:0])),
            "taken");
        if (expTaken(k[3:0], f[3:0]))
          cmp(pcValue, tgt, "branch target");
      end
    end
    setFlags(4'hf);
    call(bcb_pkg::ABSOLUTE_JUMP, 24'habcdef, 24'h0, 1'b0);
    call(bcb_pkg::ABSOLUTE_SUBROUTINE_CALL, 24'h100000, 24'h000102,
         1'b0);
    call(bcb_pkg::RELATIVE_SUBROUTINE_CALL, 24'h200000, 24'h100004,
         1'b0);
    call(bcb_pkg::ABSOLUTE_SUBROUTINE_CALL, 24'h300000, 24'h200006,
         1'b1);
    call(bcb_pkg::OP_SUBROUTINE_RETURN, 24'h100004, 24'h0,
         1'b0);
    call(bcb_pkg::OP_SUBROUTINE_RETURN, 24'h000102, 24'h0,
         1'b0);
    call(bcb_pkg::OP_SUBROUTINE_RETURN, 24'h0, 24'h0, 1'b1);
    doOp(bcb_pkg::OP_IDLE, 4'h0, 3'h0, 8'h00, 1'b0, 8'h00, 24'h0, 24'h0);
    cmp(24'({pcLoad, resultByteWrite, stackFault}), 24'h0, "idle op");
    // An op in the same cycle as a flag load keeps the old flags
    @(posedge clk_sys);
    opValid  <= 1'b1;
    opCode   <= bcb_pkg::OP_IDLE;
    flagLoad <= 1'b1;
    flagIn   <= 4'h0;
    @(posedge clk_sys);
    opValid  <= 1'b0;
    flagLoad <= 1'b0;
    #1;
    cmp(24'({carryFlag, zeroFlag, overflowFlag, negativeFlag}), 24'hf,
        "op over flag load");
    // Call and return on consecutive edges
    @(posedge clk_sys);
    opValid    <= 1'b1;
    opCode     <= bcb_pkg::ABSOLUTE_SUBROUTINE_CALL;
    targetAddr <= 24'h400000;
    returnAddr <= 24'h000abc;
    @(posedge clk_sys);
    opCode <= bcb_pkg::OP_SUBROUTINE_RETURN;
    #1;
    cmp(pcValue, 24'h400000, "b2b call");
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    cmp(pcValue, 24'h000abc, "b2b return");
    // Reset in mid-run drops stacked returns and flags
    call(bcb_pkg::ABSOLUTE_SUBROUTINE_CALL, 24'h500000, 24'h000200, 1'b0);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    cmp(pcValue, 24'h0, "mid reset pc");
    cmp(24'({carryFlag, zeroFlag, opDone, pcLoad}), 24'h0, "mid reset");
    @(posedge clk_sys);
    rst <= 1'b0;
    call(bcb_pkg::OP_SUBROUTINE_RETURN, 24'h0, 24'h0, 1'b1);
    wrap_up();
  end

endmodule : bit_carry_logic_and_branch_unit_bench

`default_nettype wire
